// [hdl/cfg_spi_pkg.sv]
// constants shared by the configuration serial port and its register store
// assumes one 40 MHz system clock; the serial clock arrives as a plain pin input
package cfg_spi_pkg;

    // ************************************************
    // frame layout
    // ************************************************
    localparam int FRAME_BITS = 24;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam logic [9:0] BIT_CNT_MAX = 10'h3FF;
    localparam logic [9:0] FRAME_BITS_CNT = 10'h018;
    localparam logic [7:0] READ_CMD = 8'hFE;

    // ************************************************
    // bank 0 addresses and fields
    // ************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CHAIN = 8'h01;
    localparam logic [7:0] ADDR_BANK_SEL = 8'h03;
    localparam logic [7:0] ADDR_INIT = 8'h04;
    localparam logic [7:0] ADDR_READBACK = 8'h06;
    localparam int POS_SOFT_RESET = 0;
    localparam int POS_READ_ENABLE = 1;
    localparam int POS_PORT_MODE = 2;
    localparam int POS_CHAIN_LSB = 2;
    localparam int POS_CHAIN_MSB = 6;
    localparam int POS_INIT_MSB = 3;
    localparam int POS_BANK_MSB = 7;

    // ************************************************
    // reset values and bank codes
    // ************************************************
    localparam logic RESET_PORT_MODE = 1'b0;
    localparam logic RESET_READ_ENABLE = 1'b0;
    localparam logic [4:0] RESET_CHAIN = 5'h00;
    localparam logic [7:0] RESET_BANK_SEL = 8'h02;
    localparam logic [3:0] RESET_INIT = 4'h0;
    localparam logic [7:0] BANK_CODE_0 = 8'h00;
    localparam logic [7:0] BANK_CODE_1 = 8'h02;
    localparam logic [7:0] BANK_CODE_2 = 8'h10;

    typedef enum logic [1:0] {
        BANK_NONE,
        BANK_ONE,
        BANK_TWO
    } bank_t;

endpackage

// [hdl/store_if.sv]
// carrier between the serial port logic and the bank 1 and bank 2 store
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface store_if;
    logic wr_en;
    logic wr_bank;
    logic clear;
    logic [7:0] addr;
    logic rd_bank;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    modport ctrl (output wr_en, output wr_bank, output clear, output addr, output rd_bank,
        output wr_data, input rd_data);
    modport store (input wr_en, input wr_bank, input clear, input addr, input rd_bank,
        input wr_data, output rd_data);
endinterface

// [hdl/bank_store.sv]
// storage for register banks 1 and 2, 256 words of 16 bits each
// assumes the port logic drives the carrier; reads are combinational
`timescale 1ns/1ps
module bank_store
    import cfg_spi_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    store_if.store st
);
    typedef struct packed {
        logic [255:0][15:0] bank_one;
        logic [255:0][15:0] bank_two;
    } store_state_t;

    store_state_t s_reg;
    store_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (st.clear) begin
            s_next = '0;
        end else if (st.wr_en) begin
            if (st.wr_bank) begin
                s_next.bank_two[st.addr] = st.wr_data;
            end else begin
                s_next.bank_one[st.addr] = st.wr_data;
            end
        end
    end

    assign st.rd_data = st.rd_bank ? s_reg.bank_two[st.addr] : s_reg.bank_one[st.addr];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// [hdl/cfg_spi_port.sv]
// configuration serial port: legacy point-to-point and daisy-chain modes
// assumes serial pins are asynchronous to mclk and sclk is at most mclk/8
//
// Summary of operation
// - writes accepted with reads disabled, in daisy mode, or to register 0
// - 16-bit registers, three banks, 8-bit address
// - bank 0 reachable regardless of selector
// - selector 0, 2, 16 pick banks 0-2
// - legacy read answers in next frame
// - address in 23:16, data in 15:0
// - idle output: hi-z legacy, zero daisy
// - daisy mode delays input 24 clocks
// - daisy-chain mode after reset
// - each device latches resident word at release
// - FE command in daisy mode loads address and data out
// - port mode bit: 0 daisy, 1 legacy
// - read enable ignored in daisy mode
`timescale 1ns/1ps
module cfg_spi_port
    import cfg_spi_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic port_mode_legacy,
    output logic read_enable,
    output logic [4:0] chain_length_field,
    output logic [7:0] bank_select,
    output logic [3:0] init_field
);
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sclk_sync;
        logic [1:0] sdi_sync;
        logic cs_prev;
        logic sclk_prev;
        logic [23:0] shift;
        logic [9:0] bit_cnt;
        logic resp_valid;
        logic sdo;
        logic sdo_oe;
        logic legacy;
        logic rd_en;
        logic [4:0] chain_len;
        logic [7:0] bank_sel;
        logic [3:0] init;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;
    store_if st();

    logic rise;
    logic fall;
    logic active;
    logic start;
    logic stop;
    logic frame_ok;
    logic read_cmd;
    logic legacy_read;
    logic write_ok;
    logic [7:0] frame_addr;
    logic [15:0] frame_data;
    logic [7:0] target;
    bank_t target_bank;

    // ************************************************
    // decoding helpers
    // ************************************************
    // selector decode
    function automatic bank_t bank_of(input logic [7:0] sel);
        if (sel == BANK_CODE_1) begin
            return BANK_ONE;
        end else if (sel == BANK_CODE_2) begin
            return BANK_TWO;
        end
        return BANK_NONE;
    endfunction

    function automatic logic is_bank0(input logic [7:0] a);
        return (a == ADDR_CONTROL) || (a == ADDR_CHAIN) || (a == ADDR_BANK_SEL) ||
            (a == ADDR_INIT) || (a == ADDR_READBACK);
    endfunction

    // ************************************************
    // frame events from synchronised pins
    // ************************************************
    // only the second stage of each synchroniser is read here
    assign rise = s_reg.sclk_sync[1] & ~s_reg.sclk_prev;
    assign fall = ~s_reg.sclk_sync[1] & s_reg.sclk_prev;
    assign active = ~s_reg.cs_sync[1];
    assign start = ~s_reg.cs_sync[1] & s_reg.cs_prev;
    assign stop = s_reg.cs_sync[1] & ~s_reg.cs_prev;

    assign frame_addr = s_reg.shift[ADDR_MSB:ADDR_LSB];
    assign frame_data = s_reg.shift[DATA_MSB:0];
    // daisy words need at least one full word; legacy exactly one
    assign frame_ok = s_reg.legacy ? (s_reg.bit_cnt == FRAME_BITS_CNT)
                                   : (s_reg.bit_cnt >= FRAME_BITS_CNT);
    assign read_cmd = ~s_reg.legacy && (frame_addr == READ_CMD);
    // read enable only counts in legacy mode
    assign legacy_read = s_reg.legacy && s_reg.rd_en && (frame_addr != ADDR_CONTROL);
    // register 0 stays writable so reads can be switched off again
    assign write_ok = ~s_reg.legacy || ~s_reg.rd_en || (frame_addr == ADDR_CONTROL);
    assign target = read_cmd ? s_reg.shift[7:0] : frame_addr;
    assign target_bank = bank_of(s_reg.bank_sel);
    // kept out of the next-state process: the read data depends on them
    assign st.addr = target;
    assign st.wr_data = frame_data;
    assign st.wr_bank = (target_bank == BANK_TWO);
    assign st.rd_bank = (target_bank == BANK_TWO);

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [15:0] rd_value;
        rd_value = 16'h0000;
        s_next = s_reg;
        s_next.cs_sync = {s_reg.cs_sync[0], cs_n};
        s_next.sclk_sync = {s_reg.sclk_sync[0], sclk};
        s_next.sdi_sync = {s_reg.sdi_sync[0], sdi};
        s_next.cs_prev = s_reg.cs_sync[1];
        s_next.sclk_prev = s_reg.sclk_sync[1];
        st.wr_en = 1'b0;
        st.clear = 1'b0;

        // read mux over bank 0 and the selected bank
        if (target == ADDR_CONTROL || target == ADDR_READBACK) begin
            rd_value = 16'h0000;
            rd_value[POS_PORT_MODE] = s_reg.legacy;
            rd_value[POS_READ_ENABLE] = s_reg.rd_en;
        end else if (target == ADDR_CHAIN) begin
            rd_value[POS_CHAIN_MSB:POS_CHAIN_LSB] = s_reg.chain_len;
        end else if (target == ADDR_BANK_SEL) begin
            rd_value[POS_BANK_MSB:0] = s_reg.bank_sel;
        end else if (target == ADDR_INIT) begin
            rd_value[POS_INIT_MSB:0] = s_reg.init;
        end else if (target_bank != BANK_NONE) begin
            rd_value = st.rd_data;
        end

        if (start) begin
            s_next.bit_cnt = 10'h000;
            s_next.sdo = s_reg.shift[ADDR_MSB];
            s_next.sdo_oe = s_reg.legacy ? s_reg.resp_valid : 1'b1;
        end else if (active && rise) begin
            s_next.shift = {s_reg.shift[22:0], s_reg.sdi_sync[1]};
            if (s_reg.bit_cnt != BIT_CNT_MAX) begin
                s_next.bit_cnt = s_reg.bit_cnt + 10'h001;
            end
        end else if (active && fall) begin
            // bit leaves after a full word of clocks
            s_next.sdo = s_reg.shift[ADDR_MSB];
        end

        if (stop) begin
            s_next.shift = 24'h00_0000;
            s_next.resp_valid = 1'b0;
            if (frame_ok) begin
                if (read_cmd) begin
                    // load address and data for the next frame
                    s_next.shift = {target, rd_value};
                    s_next.resp_valid = 1'b1;
                end else if (legacy_read) begin
                    s_next.shift = {8'h00, rd_value};
                    s_next.resp_valid = 1'b1;
                end else if (write_ok) begin
                    // bank 0 writes ignore the selector
                    if (frame_addr == ADDR_CONTROL) begin
                        if (frame_data[POS_SOFT_RESET]) begin
                            s_next.legacy = RESET_PORT_MODE;
                            s_next.rd_en = RESET_READ_ENABLE;
                            s_next.chain_len = RESET_CHAIN;
                            s_next.bank_sel = RESET_BANK_SEL;
                            s_next.init = RESET_INIT;
                            st.clear = 1'b1;
                        end else begin
                            s_next.legacy = frame_data[POS_PORT_MODE];
                            s_next.rd_en = frame_data[POS_READ_ENABLE];
                        end
                    end else if (frame_addr == ADDR_CHAIN) begin
                        s_next.chain_len = frame_data[POS_CHAIN_MSB:POS_CHAIN_LSB];
                    end else if (frame_addr == ADDR_BANK_SEL) begin
                        s_next.bank_sel = frame_data[POS_BANK_MSB:0];
                    end else if (frame_addr == ADDR_INIT) begin
                        s_next.init = frame_data[POS_INIT_MSB:0];
                    end else if (!is_bank0(frame_addr) && target_bank != BANK_NONE) begin
                        st.wr_en = 1'b1;
                    end
                end
            end
            s_next.sdo = 1'b0;
            // idle: released in legacy, low in daisy
            s_next.sdo_oe = ~s_next.legacy;
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.cs_sync <= 2'h3;
            s_reg.cs_prev <= 1'b1;
            s_reg.sdo_oe <= 1'b1;
            s_reg.legacy <= RESET_PORT_MODE;
            s_reg.rd_en <= RESET_READ_ENABLE;
            s_reg.chain_len <= RESET_CHAIN;
            s_reg.bank_sel <= RESET_BANK_SEL;
            s_reg.init <= RESET_INIT;
        end else begin
            s_reg <= s_next;
        end
    end

    bank_store u_store (
        .mclk(mclk),
        .reset_n(reset_n),
        .st(st.store)
    );

    assign sdo = s_reg.sdo;
    assign sdo_oe = s_reg.sdo_oe;
    assign port_mode_legacy = s_reg.legacy;
    assign read_enable = s_reg.rd_en;
    assign chain_length_field = s_reg.chain_len;
    assign bank_select = s_reg.bank_sel;
    assign init_field = s_reg.init;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_write_blocked;
        stop && frame_ok && legacy_read && frame_addr == ADDR_BANK_SEL |=> $stable(bank_select);
    endproperty
    a_write_blocked: assert property (p_write_blocked)
        else $error("bank selector changed while reads enabled");

    property p_bank_store_sel;
        st.wr_en |-> (st.wr_bank ? s_reg.bank_sel == BANK_CODE_2 : s_reg.bank_sel == BANK_CODE_1);
    endproperty
    a_bank_store_sel: assert property (p_bank_store_sel)
        else $error("bank write with wrong selector");

    property p_bank0_write;
        stop && frame_ok && write_ok && !read_cmd && frame_addr == ADDR_BANK_SEL
            |=> bank_select == $past(frame_data[7:0]);
    endproperty
    a_bank0_write: assert property (p_bank0_write)
        else $error("selector write lost");

    property p_legacy_answer;
        stop && frame_ok && legacy_read |=> s_reg.resp_valid && s_reg.shift[23:16] == 8'h00;
    endproperty
    a_legacy_answer: assert property (p_legacy_answer)
        else $error("legacy read not loaded");

    property p_idle_output;
        s_reg.cs_sync[1] && s_reg.cs_prev |-> (sdo == 1'b0) && (sdo_oe == !port_mode_legacy);
    endproperty
    a_idle_output: assert property (p_idle_output)
        else $error("idle serial output wrong");

    property p_daisy_forward;
        !port_mode_legacy && active && fall |=> sdo == $past(s_reg.shift[23]);
    endproperty
    a_daisy_forward: assert property (p_daisy_forward)
        else $error("daisy output not forwarded");

    property p_reset_mode;
        $rose(reset_n) |-> !port_mode_legacy && bank_select == RESET_BANK_SEL;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("wrong mode after reset");

    property p_chain_latch;
        stop && !port_mode_legacy && frame_ok && frame_addr == ADDR_CHAIN
            |=> chain_length_field == $past(frame_data[6:2]);
    endproperty
    a_chain_latch: assert property (p_chain_latch)
        else $error("chain length not latched");

    property p_read_cmd_load;
        stop && frame_ok && read_cmd |=> s_reg.shift[23:16] == $past(s_reg.shift[7:0]);
    endproperty
    a_read_cmd_load: assert property (p_read_cmd_load)
        else $error("read command address not loaded");

    property p_msb_first;
        !start && active && rise |=> s_reg.shift[0] == $past(s_reg.sdi_sync[1]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("shift order wrong");

    c_legacy_read: cover property (stop && frame_ok && legacy_read);
    c_daisy_read: cover property (stop && frame_ok && read_cmd);
    c_store_write: cover property (st.wr_en);
    c_soft_reset: cover property (st.clear);
endmodule

// [verification/spi_ctrl_model.sv]
// serial controller model: drives chip select, serial clock and data, captures the return line
// assumes mclk at 40 MHz; one serial clock period spans 8 mclk, mode 0, clock idle low
`timescale 1ns/1ps
module spi_ctrl_model (
    input wire logic mclk,
    input wire logic sdo_line,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // ************************************************
    // frame transfer
    // ************************************************
    // msb first, framed
    task automatic xfer(input int nw, input logic [95:0] tx, output logic [95:0] rx);
        int i;
        rx = '0;
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (8) @(posedge mclk);
        for (i = nw * 24 - 1; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            // sample 2 mclk into the 4 mclk high phase, well clear of the synchroniser delay
            repeat (2) @(posedge mclk);
            rx[i] = sdo_line;
            repeat (2) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        // a released data line must not look like a held bit
        sdi <= ~tx[0];
        repeat (8) @(posedge mclk);
    endtask
endmodule

// [verification/adc_config_spi_daisy_chain_tb.sv]
// self-checking bench for the configuration serial port against a behavioural register model
// assumes a single device in the chain and the controller model in spi_ctrl_model
`timescale 1ns/1ps
module adc_config_spi_daisy_chain_tb;
    import cfg_spi_pkg::*;
    logic mclk;
    logic reset_n;
    logic cs_n, sclk, sdi, sdo, sdo_oe, sdo_held, port_mode_legacy, read_enable;
    logic [4:0] chain_length_field;
    logic [7:0] bank_select;
    logic [3:0] init_field;
    wire sdo_line;
    int error_cnt = 0;
    int n_checks = 0;
    logic [31:0] lfsr_state = 32'ha946_36f8;
    logic [95:0] rx_word;
    logic m_leg, m_rden;
    logic [4:0] m_chain;
    logic [7:0] m_bsel;
    logic [3:0] m_init;
    logic [23:0] m_resp, exp_resp;
    int mem[2][256];

    // released output line shows the inverse of its last driven value
    always @(posedge mclk) if (sdo_oe) sdo_held <= sdo;
    assign sdo_line = sdo_oe ? sdo : ~sdo_held;

    cfg_spi_port dut_u (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .port_mode_legacy(port_mode_legacy),
        .read_enable(read_enable), .chain_length_field(chain_length_field),
        .bank_select(bank_select), .init_field(init_field));
    spi_ctrl_model ctrl_u (.mclk(mclk), .sdo_line(sdo_line), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ************************************************
    // reference model
    // ************************************************
    function automatic logic [31:0] next_rnd();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
            ^ lfsr_state[0]};
        return lfsr_state;
    endfunction

    task automatic mdl_reset();
        m_leg = RESET_PORT_MODE;
        m_rden = RESET_READ_ENABLE;
        m_chain = RESET_CHAIN;
        m_bsel = RESET_BANK_SEL;
        m_init = RESET_INIT;
        foreach (mem[b, a]) mem[b][a] = 0;
    endtask

    function automatic logic [15:0] rd(input logic [7:0] a);
        // bank 0 reads ignore the selector
        if (a == ADDR_CONTROL || a == ADDR_READBACK) return {13'h0000, m_leg, m_rden, 1'b0};
        if (a == ADDR_CHAIN) return {9'h000, m_chain, 2'b00};
        if (a == ADDR_BANK_SEL) return {8'h00, m_bsel};
        if (a == ADDR_INIT) return {12'h000, m_init};
        if (m_bsel == BANK_CODE_1) return mem[0][a][15:0];
        if (m_bsel == BANK_CODE_2) return mem[1][a][15:0];
        return 16'h0000;
    endfunction

    task automatic mdl_word(input logic [23:0] w);
        logic [7:0] a;
        logic [15:0] d;
        a = w[23:16];
        d = w[15:0];
        if (!m_leg && a == READ_CMD) m_resp = {w[7:0], rd(w[7:0])};
        else if (m_leg && m_rden && a != ADDR_CONTROL) m_resp = {8'h00, rd(a)};
        else if (a == ADDR_CONTROL && d[0]) mdl_reset();
        else if (a == ADDR_CONTROL) {m_leg, m_rden} = d[2:1];
        else if (a == ADDR_CHAIN) m_chain = d[6:2];
        else if (a == ADDR_BANK_SEL) m_bsel = d[7:0];
        else if (a == ADDR_INIT) m_init = d[3:0];
        else if (m_bsel == BANK_CODE_1) mem[0][a] = d;
        else if (m_bsel == BANK_CODE_2) mem[1][a] = d;
    endtask

    // ************************************************
    // checks and transfers
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check_regs();
        check(port_mode_legacy, m_leg);
        check(read_enable, m_rden);
        check(chain_length_field, m_chain);
        check(bank_select, m_bsel);
        check(init_field, m_init);
    endtask

    task automatic frame(input int nw, input logic [95:0] tx);
        exp_resp = m_resp;
        ctrl_u.xfer(nw, tx, rx_word);
        mdl_word(tx[23:0]);
    endtask

    task automatic send(input logic [7:0] a, input logic [15:0] d);
        frame(1, {72'h0, a, d});
    endtask

    initial begin
        #2_000_000;
        error_cnt++;
        end_of_test();
    end

    // ************************************************
    // scenarios
    // ************************************************
    initial begin : main
        logic [31:0] r;
        logic [7:0] a;
        logic [7:0] codes[3];
        int k;
        codes = '{BANK_CODE_1, BANK_CODE_2, 8'h05};
        reset_n = 1'b0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        mdl_reset();
        check_regs();
        check(sdo_oe, 1'b1);
        check(sdo, 1'b0);
        // chain length after reset, filler word ahead of it
        r = next_rnd();
        frame(2, {48'h0, r[23:0], ADDR_CHAIN, 9'h000, r[28:24], 2'b00});
        check(rx_word[23:0], r[23:0]);
        check_regs();
        // read enable set in daisy mode must not change daisy behaviour
        send(ADDR_CONTROL, 16'h0002);
        // chained read of the mode readback register
        send(READ_CMD, {8'h00, ADDR_READBACK});
        frame(1, {72'h0, 24'hFF_FFFF});
        check(rx_word[23:0], exp_resp);
        for (k = 0; k < 3; k++) begin
            r = next_rnd();
            a = {2'b01, r[5:0]};
            send(ADDR_BANK_SEL, {8'h00, codes[k]});
            send(a, r[31:16]);
            send(ADDR_INIT, (k == 1 || (k == 2 && !r[8])) ? 16'h0000 : 16'h000B);
            check_regs();
            send(READ_CMD, {8'h00, a});
            frame(1, {72'h0, 24'hFF_FFFF});
            check(rx_word[23:0], exp_resp);
        end
        // bank selection happens with reads disabled
        send(ADDR_CONTROL, 16'h0000);
        r = next_rnd();
        send(ADDR_BANK_SEL, {8'h00, BANK_CODE_1});
        send(8'h0D, r[15:0]);
        send(8'h33, 16'h2040);
        send(ADDR_CONTROL, 16'h0006);
        check_regs();
        check(sdo_oe, 1'b0);
        // read requests carry a zero data field
        send(8'h33, 16'h0000);
        send(8'h0D, 16'h0000);
        check(rx_word[23:0], exp_resp);
        // a read of the selector must not overwrite it
        send(ADDR_BANK_SEL, 16'h0000);
        check(rx_word[23:0], exp_resp);
        send(ADDR_CONTROL, 16'h0004);
        check(rx_word[23:0], exp_resp);
        check_regs();
        send(8'h33, r[31:16]);
        send(ADDR_CONTROL, 16'h0006);
        send(8'h33, 16'h0000);
        send(ADDR_CONTROL, 16'h0004);
        check(rx_word[23:0], exp_resp);
        // soft reset returns daisy mode and clears the store
        send(ADDR_CONTROL, 16'h0001);
        check_regs();
        check(sdo_oe, 1'b1);
        send(READ_CMD, {8'h00, a});
        frame(1, {72'h0, 24'hFF_FFFF});
        check(rx_word[23:0], exp_resp);
        end_of_test();
    end
endmodule
